// ### common/ieflg_pkg.sv
package ieflg_pkg;
    // ==========================================================
    // register map (byte offsets on the plain port)
    localparam logic [7:0] IEFLG_CORE_CTRL_ADDR = 8'h0B;
    localparam logic [7:0] IEFLG_CORE_CTRL_ALT_ADDR = 8'h8B;
    localparam logic [7:0] IEFLG_PERIPH_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] IEFLG_PERIPH_ENABLE_ADDR = 8'h8C;
    // ==========================================================
    // core control bit positions
    localparam int IEFLG_GLOBAL_EN_BIT = 7;
    localparam int IEFLG_GROUP_EN_BIT = 6;
    localparam int IEFLG_TIMER_ZERO_EN_BIT = 5;
    localparam int IEFLG_EXT_EN_BIT = 4;
    localparam int IEFLG_PORT_EN_BIT = 3;
    localparam int IEFLG_TIMER_ZERO_FLAG_BIT = 2;
    localparam int IEFLG_EXT_FLAG_BIT = 1;
    localparam int IEFLG_PORT_FLAG_BIT = 0;
    // ==========================================================
    // peripheral bit positions, shared by enable and flag registers
    localparam int IEFLG_CONV_BIT = 6;
    localparam int IEFLG_CAPCOMP_BIT = 2;
    localparam int IEFLG_PERIOD_BIT = 1;
    localparam int IEFLG_TIMER1_BIT = 0;
    localparam logic [7:0] IEFLG_PERIPH_MASK = 8'h47;
    // ==========================================================
    // reset values
    localparam logic [7:0] IEFLG_CORE_CTRL_RESET = 8'h00;
    localparam logic [7:0] IEFLG_PERIPH_RESET = 8'h00;
    localparam logic [3:0] IEFLG_NIBBLE_RESET = 4'h0;
endpackage

// ### design/ieflg_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser plus one registered copy for edge/change compare
module ieflg_edge_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // pins
    input wire logic [4:0] pins_in,
    // synchronised level and previous level
    output logic [4:0] level_out,
    output logic [4:0] prev_out
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] level;
        logic [4:0] prev;
    } ieflg_sync_type;
    ieflg_sync_type state;
    ieflg_sync_type next_state;
    always_comb begin
        next_state = state;
        // meta is read only by the second stage
        next_state.meta = pins_in;
        next_state.level = state.meta;
        next_state.prev = state.level;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign level_out = state.level;
    assign prev_out = state.prev;
endmodule // ieflg_edge_sync
`default_nettype wire

// ### design/ieflg_interrupt_logic.sv
`timescale 1ns/1ps
`default_nettype none
module ieflg_interrupt_logic (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // pins
    input wire logic external_edge_pin_in,
    input wire logic [3:0] port_b_upper_nibble_in,
    input wire logic edge_rising_select_in,
    // peripheral event pulses, same clock
    input wire logic timer_zero_rollover_in,
    input wire logic converter_done_in,
    input wire logic capcomp_event_in,
    input wire logic period_match_in,
    input wire logic timer1_overflow_in,
    // core side
    output logic irq_request_out,
    output logic [7:0] core_irq_control_out,
    output logic [7:0] peripheral_irq_flags_out
);
    import ieflg_pkg::*;

    typedef struct packed {
        logic [7:0] core_irq_control;
        logic [7:0] peripheral_irq_enable;
        logic [7:0] peripheral_irq_flags;
        logic [7:0] rdata;
        logic irq;
    } ieflg_state_type;

    ieflg_state_type state;
    ieflg_state_type next_state;
    logic [4:0] pin_level;
    logic [4:0] pin_prev;
    logic ext_event;
    logic port_event;
    logic core_wr;
    logic flags_wr;
    logic enable_wr;
    logic core_pend;
    logic periph_pend;

    // ==========================================================
    // pin synchronisation
    ieflg_edge_sync u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pins_in({port_b_upper_nibble_in, external_edge_pin_in}),
        .level_out(pin_level),
        .prev_out(pin_prev)
    );

    // edge select is a register bit elsewhere, taken here as a level
    assign ext_event = edge_rising_select_in ? (pin_level[0] & ~pin_prev[0])
                                             : (~pin_level[0] & pin_prev[0]);
    // any upper pin change; level and prev reset equal, but a pin high at reset release still reads as one change
    assign port_event = |(pin_level[4:1] ^ pin_prev[4:1]);

    // ==========================================================
    // address decode
    function automatic logic is_core(input logic [7:0] a);
        is_core = (a == IEFLG_CORE_CTRL_ADDR) || (a == IEFLG_CORE_CTRL_ALT_ADDR);
    endfunction

    assign core_wr = wr_in && is_core(addr_in);
    assign flags_wr = wr_in && (addr_in == IEFLG_PERIPH_FLAGS_ADDR);
    assign enable_wr = wr_in && (addr_in == IEFLG_PERIPH_ENABLE_ADDR);

    // set wins over a software clear in the same cycle
    function automatic logic sticky(input logic cur, input logic wr, input logic wbit,
                                    input logic ev);
        sticky = ev | (wr ? wbit : cur);
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        next_state = state;
        if (core_wr) begin
            next_state.core_irq_control = wdata_in;
        end
        if (enable_wr) begin
            next_state.peripheral_irq_enable = wdata_in & IEFLG_PERIPH_MASK;
        end
        // flags set whatever the enables say
        next_state.core_irq_control[IEFLG_TIMER_ZERO_FLAG_BIT] = sticky(
            state.core_irq_control[IEFLG_TIMER_ZERO_FLAG_BIT], core_wr,
            wdata_in[IEFLG_TIMER_ZERO_FLAG_BIT], timer_zero_rollover_in);
        next_state.core_irq_control[IEFLG_EXT_FLAG_BIT] = sticky(
            state.core_irq_control[IEFLG_EXT_FLAG_BIT], core_wr,
            wdata_in[IEFLG_EXT_FLAG_BIT], ext_event);
        next_state.core_irq_control[IEFLG_PORT_FLAG_BIT] = sticky(
            state.core_irq_control[IEFLG_PORT_FLAG_BIT], core_wr,
            wdata_in[IEFLG_PORT_FLAG_BIT], port_event);
        next_state.peripheral_irq_flags[IEFLG_CONV_BIT] = sticky(
            state.peripheral_irq_flags[IEFLG_CONV_BIT], flags_wr,
            wdata_in[IEFLG_CONV_BIT], converter_done_in);
        next_state.peripheral_irq_flags[IEFLG_CAPCOMP_BIT] = sticky(
            state.peripheral_irq_flags[IEFLG_CAPCOMP_BIT], flags_wr,
            wdata_in[IEFLG_CAPCOMP_BIT], capcomp_event_in);
        next_state.peripheral_irq_flags[IEFLG_PERIOD_BIT] = sticky(
            state.peripheral_irq_flags[IEFLG_PERIOD_BIT], flags_wr,
            wdata_in[IEFLG_PERIOD_BIT], period_match_in);
        next_state.peripheral_irq_flags[IEFLG_TIMER1_BIT] = sticky(
            state.peripheral_irq_flags[IEFLG_TIMER1_BIT], flags_wr,
            wdata_in[IEFLG_TIMER1_BIT], timer1_overflow_in);
        next_state.peripheral_irq_flags = next_state.peripheral_irq_flags
                                          & IEFLG_PERIPH_MASK;
        // read data valid the cycle after the strobe only
        next_state.rdata = 8'h00;
        if (rd_in) begin
            if (is_core(addr_in)) begin
                next_state.rdata = state.core_irq_control;
            end else if (addr_in == IEFLG_PERIPH_FLAGS_ADDR) begin
                next_state.rdata = state.peripheral_irq_flags;
            end else if (addr_in == IEFLG_PERIPH_ENABLE_ADDR) begin
                next_state.rdata = state.peripheral_irq_enable;
            end
        end
        next_state.irq = state.core_irq_control[IEFLG_GLOBAL_EN_BIT]
                         && (core_pend || periph_pend);
    end

    // ==========================================================
    // request gating from current registers
    always_comb begin
        core_pend = (state.core_irq_control[IEFLG_TIMER_ZERO_EN_BIT]
                     && state.core_irq_control[IEFLG_TIMER_ZERO_FLAG_BIT])
                    || (state.core_irq_control[IEFLG_EXT_EN_BIT]
                        && state.core_irq_control[IEFLG_EXT_FLAG_BIT])
                    || (state.core_irq_control[IEFLG_PORT_EN_BIT]
                        && state.core_irq_control[IEFLG_PORT_FLAG_BIT]);
        // enables share bit positions, so one AND
        periph_pend = state.core_irq_control[IEFLG_GROUP_EN_BIT]
                      && |(state.peripheral_irq_enable
                           & state.peripheral_irq_flags);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state.core_irq_control <= IEFLG_CORE_CTRL_RESET;
            state.peripheral_irq_enable <= IEFLG_PERIPH_RESET;
            state.peripheral_irq_flags <= IEFLG_PERIPH_RESET;
            state.rdata <= 8'h00;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata_out = state.rdata;
    assign irq_request_out = state.irq;
    assign core_irq_control_out = state.core_irq_control;
    assign peripheral_irq_flags_out = state.peripheral_irq_flags;
endmodule // ieflg_interrupt_logic
`default_nettype wire

// ### sim/ieflg_props.sv
`timescale 1ns/1ps
`default_nettype none
module ieflg_props (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port and event pulses
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic timer_zero_rollover_in,
    input wire logic converter_done_in,
    input wire logic capcomp_event_in,
    input wire logic period_match_in,
    input wire logic timer1_overflow_in,
    // core side
    input wire logic irq_request_out,
    input wire logic [7:0] core_irq_control_out,
    input wire logic [7:0] peripheral_irq_flags_out
);
    import ieflg_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic [7:0] c = core_irq_control_out;
    wire logic [7:0] f = peripheral_irq_flags_out;
    wire logic [7:0] ev = {1'b0, converter_done_in, 3'h0, capcomp_event_in,
        period_match_in, timer1_overflow_in};
    wire logic hit = c[7] && (c[5] && c[2] || c[4] && c[1] || c[3] && c[0]);
    sequence timer_zero_armed_s;
        c[7] && c[5] && timer_zero_rollover_in && !wr_in;
    endsequence
    glob_gate_a: assert property (irq_request_out |-> $past(c[7]))
        else $error("irq without global enable");
    core_gate_a: assert property ($past(hit) |-> irq_request_out)
        else $error("enabled core flag gave no irq");
    group_gate_a: assert property (irq_request_out && !$past(hit) |->
        $past(c[6] && f != 8'h00)) else $error("peripheral irq without group enable");
    timer_zero_irq_a: assert property (timer_zero_armed_s |-> ##2 irq_request_out)
        else $error("rollover did not raise irq in two cycles");
    periph_set_a: assert property (ev != 8'h00 |=> (f & $past(ev)) == $past(ev))
        else $error("peripheral flag not set");
    pflag_hold_a: assert property (!wr_in |=> (f & $past(f)) == $past(f))
        else $error("peripheral flag lost");
    cflag_hold_a: assert property (!wr_in |=> (c[2:0] & $past(c[2:0])) == $past(c[2:0]))
        else $error("core flag lost");
    unused_read_a: assert property ($past(rd_in && addr_in == IEFLG_PERIPH_ENABLE_ADDR) |->
        (rdata_out & ~IEFLG_PERIPH_MASK) == 8'h00) else $error("unused enable bit read nonzero");
endmodule // ieflg_props
bind ieflg_interrupt_logic ieflg_props i_ieflg_props (.*);
`default_nettype wire

// ### sim/ieflg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ieflg_core_model (
    // clock
    input wire logic clk_in,
    // register port toward the block
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [7:0] rdata_in
);
    import ieflg_pkg::*;
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // idle cycle after each strobe so no signal is set twice in one step
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        d = rdata_in;
    endtask
    // flags cleared before enables go up
    task automatic arm(input logic [7:0] ctl, input logic [7:0] pie);
        wr8(IEFLG_CORE_CTRL_ADDR, 8'h00);
        wr8(IEFLG_PERIPH_FLAGS_ADDR, 8'h00);
        wr8(IEFLG_PERIPH_ENABLE_ADDR, pie);
        wr8(IEFLG_CORE_CTRL_ADDR, ctl);
    endtask
endmodule // ieflg_core_model
`default_nettype wire

// ### sim/tb_interrupt_enable_flag_logic.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
module tb_interrupt_enable_flag_logic;
    import ieflg_pkg::*;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] pie;
        logic [6:0] ev;
        logic sel;
        logic irq;
        logic [2:0] cf;
        logic [7:0] pf;
    } ieflg_row_type;
    // ev: port, ext, timer_zero, conv, capcomp, period, timer1
    ieflg_row_type rows [13] = '{
        '{8'hA0, 8'h00, 7'h10, 1'b1, 1'b1, 3'h4, 8'h00},
        '{8'h80, 8'h00, 7'h10, 1'b1, 1'b0, 3'h4, 8'h00},
        '{8'h20, 8'h00, 7'h10, 1'b1, 1'b0, 3'h4, 8'h00},
        '{8'h90, 8'h00, 7'h20, 1'b1, 1'b1, 3'h2, 8'h00},
        '{8'h80, 8'h00, 7'h20, 1'b0, 1'b0, 3'h2, 8'h00},
        '{8'h88, 8'h00, 7'h40, 1'b1, 1'b1, 3'h1, 8'h00},
        '{8'h80, 8'h00, 7'h40, 1'b1, 1'b0, 3'h1, 8'h00},
        '{8'hC0, 8'h40, 7'h08, 1'b1, 1'b1, 3'h0, 8'h40},
        '{8'h80, 8'h40, 7'h08, 1'b1, 1'b0, 3'h0, 8'h40},
        '{8'hC0, 8'h04, 7'h04, 1'b1, 1'b1, 3'h0, 8'h04},
        '{8'hC0, 8'h01, 7'h02, 1'b1, 1'b0, 3'h0, 8'h02},
        '{8'hC0, 8'h02, 7'h02, 1'b1, 1'b1, 3'h0, 8'h02},
        '{8'hC0, 8'h01, 7'h01, 1'b1, 1'b1, 3'h0, 8'h01}};
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr, wdata, rdata, ctl_out, pf_out, d;
    logic wr, rd, ext = 1'b0, sel = 1'b1, irq;
    logic [3:0] nib = 4'h0;
    logic [4:0] evs = 5'h00;
    int err_total = 0;
    int compares = 0;
    always #20 clk_in = ~clk_in;
    ieflg_core_model i_ieflg_core_model (.clk_in(clk_in), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    ieflg_interrupt_logic i_ieflg_interrupt_logic (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .external_edge_pin_in(ext), .port_b_upper_nibble_in(nib), .edge_rising_select_in(sel),
        .timer_zero_rollover_in(evs[4]), .converter_done_in(evs[3]), .capcomp_event_in(evs[2]),
        .period_match_in(evs[1]), .timer1_overflow_in(evs[0]), .irq_request_out(irq),
        .core_irq_control_out(ctl_out), .peripheral_irq_flags_out(pf_out));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================
    // watchdog, well past the ~240 cycle run
    initial begin
        repeat (4000) @(posedge clk_in);
        err_total++;
        stop_test();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        `CHK(ctl_out | pf_out, 8'h00)
        i_ieflg_core_model.rd8(IEFLG_PERIPH_ENABLE_ADDR, d);
        `CHK(d, 8'h00)
        for (int i = 0; i < 13; i++) begin
            sel <= rows[i].sel;
            i_ieflg_core_model.arm(rows[i].ctl, rows[i].pie);
            evs <= rows[i].ev[4:0];
            ext <= ext ^ rows[i].ev[5];
            nib[2] <= nib[2] ^ rows[i].ev[6];
            @(posedge clk_in);
            evs <= 5'h00;
            // pins need sync stages before the flag lands
            repeat (6) @(posedge clk_in);
            `CHK(irq, rows[i].irq)
            `CHK(ctl_out[2:0], rows[i].cf)
            `CHK(pf_out, rows[i].pf)
            $display("row %0d done", i);
        end
        i_ieflg_core_model.wr8(IEFLG_PERIPH_ENABLE_ADDR, 8'hFF);
        i_ieflg_core_model.rd8(IEFLG_PERIPH_ENABLE_ADDR, d);
        `CHK(d, IEFLG_PERIPH_MASK)
        i_ieflg_core_model.rd8(8'h55, d);
        `CHK(d, 8'h00)
        i_ieflg_core_model.wr8(IEFLG_PERIPH_FLAGS_ADDR, 8'hFF);
        `CHK(pf_out, IEFLG_PERIPH_MASK)
        // control mirrored at the alternate address
        i_ieflg_core_model.wr8(IEFLG_CORE_CTRL_ALT_ADDR, 8'h00);
        i_ieflg_core_model.wr8(IEFLG_PERIPH_FLAGS_ADDR, 8'h00);
        i_ieflg_core_model.wr8(IEFLG_CORE_CTRL_ALT_ADDR, 8'h48);
        i_ieflg_core_model.rd8(IEFLG_CORE_CTRL_ADDR, d);
        `CHK(d, 8'h48)
        // event in the cycle of a clearing write: the set wins
        evs <= 5'h01;
        fork
            i_ieflg_core_model.wr8(IEFLG_PERIPH_FLAGS_ADDR, 8'h00);
            begin
                @(posedge clk_in);
                evs <= 5'h00;
            end
        join
        `CHK(pf_out, 8'h01)
        $display("register access test done");
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        `CHK({irq, ctl_out, pf_out}, 17'h00000)
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        `CHK({irq, ctl_out, pf_out}, 17'h00000)
        i_ieflg_core_model.rd8(IEFLG_PERIPH_ENABLE_ADDR, d);
        `CHK(d, 8'h00)
        $display("mid-run reset test done");
        stop_test();
    end
endmodule // tb_interrupt_enable_flag_logic
`default_nettype wire
